/* File: bep_pkg.sv */
package bep_pkg;
    localparam int unsigned CLK_MHZ          = 50;
    localparam int unsigned TIMEOUT_US       = 15;
    localparam int unsigned TIMEOUT_CYC      = TIMEOUT_US * CLK_MHZ;
    localparam int          TO_W             = 10;
    localparam logic [23:0] SYS_SPACE_LIMIT  = 24'h1FFFFF;
    localparam int          BYTE_W           = 8;
    localparam int          NBYTES           = 2;
    localparam int          WORD_W           = BYTE_W * NBYTES;
    localparam logic [1:0]  PAGE_INVALID     = 2'h3;
    localparam logic        PERR_RST         = 1'b0;
    localparam logic [TO_W-1:0] TO_CNT_RST   = 10'h000;

    typedef enum logic [1:0] {
        BEP_IDLE = 2'b00,
        BEP_BUSY = 2'b01,
        BEP_DONE = 2'b10
    } bep_state_e;
endpackage : bep_pkg

/* File: bep_bus_error.sv */
`timescale 1ns/1ps
module bep_bus_error
    import bep_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              cyc_start,
    input  wire logic              cyc_write,
    input  wire logic [1:0]        cyc_byte_en,
    input  wire logic [23:0]       cyc_addr,
    input  wire logic              cyc_user,
    input  wire logic              cyc_on_card,
    input  wire logic              seg_violation,
    input  wire logic [1:0]        page_space_ctl,
    input  wire logic              boot_state,
    input  wire logic [WORD_W-1:0] wr_data,
    input  wire logic [NBYTES-1:0] ram_par_in,
    input  wire logic [WORD_W-1:0] ram_rd_data,
    input  wire logic              system_bus_transfer_ack_n,
    output logic [NBYTES-1:0]      ram_par_out,
    output logic                   ram_rd_inhibit,
    output logic                   cpu_dtack,
    output logic                   cpu_bus_err,
    output logic                   parity_err
);

    function automatic logic odd_par(input logic [BYTE_W-1:0] b);
        return ~(^b);
    endfunction : odd_par

    bep_state_e            state_r, state_nxt;
    logic [TO_W-1:0]       to_cnt_r, to_cnt_nxt;
    logic                  perr_r, perr_nxt;
    logic                  dtack_r, dtack_nxt;
    logic                  berr_r, berr_nxt;
    logic [NBYTES-1:0]     par_r, par_nxt;
    logic                  inh_r, inh_nxt;
    logic                  wr_r, wr_nxt;
    logic                  on_r, on_nxt;
    logic [NBYTES-1:0]     be_r, be_nxt;
    logic                  fault;
    logic [NBYTES-1:0]     par_gen;
    logic [NBYTES-1:0]     par_bad;
    logic                  space_flt;
    logic                  seg_flt;
    logic                  page_flt;
    logic                  boot_flt;
    logic [TO_W-1:0]       wait_cnt_r, wait_cnt_nxt;

    // Per byte parity generate and check
    for (genvar i = 0; i < NBYTES; i++) begin : g_par
        assign par_gen[i] = odd_par(wr_data[i*BYTE_W +: BYTE_W]);
        assign par_bad[i] = be_r[i] & (odd_par(ram_rd_data[i*BYTE_W +: BYTE_W]) != ram_par_in[i]);
    end

    // Address-phase faults are known at the start of the cycle
    always_comb begin
        space_flt = cyc_user && (cyc_addr > SYS_SPACE_LIMIT);
        seg_flt   = seg_violation;
        page_flt  = (page_space_ctl == PAGE_INVALID);
        // Off-card reads are shut in boot state; on-card RAM writes still go
        boot_flt  = boot_state && !cyc_on_card && !cyc_write;
        fault     = space_flt || seg_flt || page_flt || perr_r;
    end

    always_comb begin
        state_nxt  = state_r;
        to_cnt_nxt = to_cnt_r;
        perr_nxt   = perr_r;
        dtack_nxt  = 1'b0;
        berr_nxt   = 1'b0;
        par_nxt    = par_r;
        inh_nxt    = boot_state;
        wr_nxt     = wr_r;
        on_nxt     = on_r;
        be_nxt     = be_r;
        unique case (state_r)
            BEP_IDLE: begin
                if (cyc_start) begin
                    wr_nxt     = cyc_write;
                    on_nxt     = cyc_on_card;
                    be_nxt     = cyc_byte_en;
                    to_cnt_nxt = TO_CNT_RST;
                    if (cyc_write) begin
                        perr_nxt = 1'b0;
                        par_nxt  = par_gen;
                    end
                    if (fault || boot_flt) begin
                        berr_nxt  = 1'b1;
                        state_nxt = BEP_DONE;
                    end else if (cyc_on_card) begin
                        dtack_nxt = 1'b1;
                        state_nxt = cyc_write ? BEP_DONE : BEP_BUSY;
                    end else begin
                        state_nxt = BEP_BUSY;
                    end
                end
            end
            BEP_BUSY: begin
                if (on_r) begin
                    // Read data is sampled now; error surfaces next cycle
                    if (!wr_r && !boot_state && (|par_bad)) begin
                        perr_nxt = 1'b1;
                    end
                    state_nxt = BEP_DONE;
                end else if (!system_bus_transfer_ack_n) begin
                    dtack_nxt = 1'b1;
                    state_nxt = BEP_DONE;
                end else if (to_cnt_r == TO_W'(TIMEOUT_CYC - 1)) begin
                    berr_nxt  = 1'b1;
                    state_nxt = BEP_DONE;
                end else begin
                    to_cnt_nxt = to_cnt_r + 1'b1;
                end
            end
            BEP_DONE: begin
                state_nxt = BEP_IDLE;
            end
            default: state_nxt = BEP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r  <= BEP_IDLE;
            to_cnt_r <= TO_CNT_RST;
            perr_r   <= PERR_RST;
            dtack_r  <= 1'b0;
            berr_r   <= 1'b0;
            par_r    <= '0;
            inh_r    <= 1'b1;
            wr_r     <= 1'b0;
            on_r     <= 1'b0;
            be_r     <= '0;
        end else begin
            state_r  <= state_nxt;
            to_cnt_r <= to_cnt_nxt;
            perr_r   <= perr_nxt;
            dtack_r  <= dtack_nxt;
            berr_r   <= berr_nxt;
            par_r    <= par_nxt;
            inh_r    <= inh_nxt;
            wr_r     <= wr_nxt;
            on_r     <= on_nxt;
            be_r     <= be_nxt;
        end
    end

    assign ram_par_out    = par_r;
    assign ram_rd_inhibit = inh_r;
    assign cpu_dtack      = dtack_r;
    assign cpu_bus_err    = berr_r;
    assign parity_err     = perr_r;

    // Off-card wait counted apart from to_cnt_r so the wait-bound and early-timeout checks do not trust it
    always_comb begin
        wait_cnt_nxt = wait_cnt_r;
        if (state_r == BEP_IDLE && cyc_start) begin
            wait_cnt_nxt = TO_CNT_RST;
        end else if (state_r == BEP_BUSY && !on_r && wait_cnt_r != TO_W'(TIMEOUT_CYC)) begin
            wait_cnt_nxt = wait_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wait_cnt_r <= TO_CNT_RST;
        end else begin
            wait_cnt_r <= wait_cnt_nxt;
        end
    end

    // Assertions
    // Address-phase faults
    sys_space_err_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_IDLE && cyc_start && cyc_user && cyc_addr > SYS_SPACE_LIMIT) |=> cpu_bus_err)
        else $error("user access to system space not faulted");

    user_low_ok_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_IDLE && cyc_start && cyc_user && cyc_addr <= SYS_SPACE_LIMIT && cyc_on_card
            && !seg_violation && page_space_ctl != PAGE_INVALID && !parity_err)
        |=> cpu_dtack)
        else $error("user access below system space refused");

    seg_err_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_IDLE && cyc_start && seg_violation) |=> cpu_bus_err && !cpu_dtack)
        else $error("segment violation not faulted");

    page_err_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_IDLE && cyc_start && page_space_ctl == PAGE_INVALID) |=> cpu_bus_err)
        else $error("invalid page not faulted");

    fault_any_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_IDLE && cyc_start && (space_flt || seg_flt || page_flt || parity_err))
        |=> cpu_bus_err && !cpu_dtack)
        else $error("faulted cycle not ended by bus error");

    // Off-card timeout and on-card acknowledge
    timeout_err_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_BUSY && !on_r && system_bus_transfer_ack_n && to_cnt_r == TO_W'(TIMEOUT_CYC - 1))
        |=> cpu_bus_err)
        else $error("off-card timeout missing");

    wait_bound_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_BUSY && !on_r) |-> wait_cnt_r < TO_W'(TIMEOUT_CYC))
        else $error("off-card wait longer than timeout");

    no_early_to_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_BUSY && !on_r && wait_cnt_r < TO_W'(TIMEOUT_CYC - 1)) |=> !cpu_bus_err)
        else $error("off-card timeout too early");

    no_oncard_to_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_IDLE && cyc_start && cyc_on_card && !fault) |=> cpu_dtack ##1 !cpu_bus_err)
        else $error("on-card cycle not acknowledged");

    oncard_fast_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_BUSY && on_r) |=> state_r == BEP_DONE && !cpu_bus_err)
        else $error("on-card cycle left waiting");

    // Parity generation, check and clearing
    par_gen_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_IDLE && cyc_start && cyc_write) |=> ^{ram_par_out[0], $past(wr_data[7:0])})
        else $error("low byte parity not odd");

    par_gen_hi_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_IDLE && cyc_start && cyc_write) |=> ^{ram_par_out[1], $past(wr_data[15:8])})
        else $error("high byte parity not odd");

    par_chk_lo_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_BUSY && on_r && !wr_r && !boot_state && be_r[0]
            && !(^{ram_rd_data[7:0], ram_par_in[0]}))
        |=> parity_err)
        else $error("bad low byte parity not flagged");

    par_chk_hi_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_BUSY && on_r && !wr_r && !boot_state && be_r[1]
            && !(^{ram_rd_data[15:8], ram_par_in[1]}))
        |=> parity_err)
        else $error("bad high byte parity not flagged");

    par_src_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!parity_err && !(state_r == BEP_BUSY && on_r)) |=> !parity_err)
        else $error("parity error raised outside a RAM read");

    par_late_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(parity_err) |-> !cpu_bus_err && !cpu_dtack)
        else $error("parity error reported in reading cycle");

    par_berr_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (parity_err && state_r == BEP_IDLE && cyc_start) |=> cpu_bus_err && !cpu_dtack)
        else $error("pending parity error not reported");

    perr_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (parity_err && state_r == BEP_IDLE && cyc_start && cyc_write) |=> !parity_err)
        else $error("parity error not cleared by write");

    perr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (parity_err && !(state_r == BEP_IDLE && cyc_start && cyc_write)) |=> parity_err)
        else $error("parity error dropped without write");

    // Boot state
    boot_inh_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        boot_state |=> ram_rd_inhibit && !$rose(parity_err))
        else $error("boot state read not inhibited");

    inh_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !boot_state |=> !ram_rd_inhibit)
        else $error("read inhibit held outside boot state");

    boot_wr_ok_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_IDLE && cyc_start && boot_state && cyc_on_card && cyc_write && !fault)
        |=> cpu_dtack)
        else $error("boot state RAM write refused");

    // Answer form
    err_excl_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !(cpu_bus_err && cpu_dtack))
        else $error("bus error with acknowledge");

    ack_pass_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == BEP_BUSY && !on_r && !system_bus_transfer_ack_n) |=> cpu_dtack && !cpu_bus_err)
        else $error("off-card acknowledge not passed on");

    pulse_once_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cpu_dtack || cpu_bus_err) |=> !cpu_dtack && !cpu_bus_err)
        else $error("answer longer than one cycle");

    oncard_rd_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        state_r == BEP_BUSY && on_r ##1 cpu_dtack == 1'b0);
    timeout_c:   cover property (@(posedge core_clk) disable iff (!rst_b) $rose(cpu_bus_err) && !on_r);
    perr_c:      cover property (@(posedge core_clk) disable iff (!rst_b) $rose(parity_err));
    system_bus_transfer_ack_n_c:      cover property (@(posedge core_clk) disable iff (!rst_b) cpu_dtack && !on_r);
    boot_wr_c:   cover property (@(posedge core_clk) disable iff (!rst_b) boot_state && cpu_dtack);

endmodule : bep_bus_error

/* File: bep_far_model.sv */
`timescale 1ns/1ps
module bep_far_model
    import bep_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              cyc_start,
    input  wire logic              cyc_write,
    input  wire logic              cyc_on_card,
    input  wire logic [WORD_W-1:0] wr_data,
    input  wire logic [NBYTES-1:0] ram_par_out,
    input  wire logic              cpu_dtack,
    input  wire logic              cpu_bus_err,
    input  wire logic [31:0]       ack_delay,
    input  wire logic              corrupt,
    output logic [WORD_W-1:0]      ram_rd_data,
    output logic [NBYTES-1:0]      ram_par_in,
    output logic                   system_bus_transfer_ack_n
);
    logic [WORD_W-1:0] mem_r = '0;
    logic [NBYTES-1:0] par_r = '0;
    logic              cap_r = 1'b0;
    int                cnt_r = 0;
    initial begin
        ram_rd_data = '0;
        ram_par_in = '0;
        system_bus_transfer_ack_n = 1'b1;
    end
    always @(posedge core_clk) begin
        cap_r <= 1'b0;
        // Parity bits arrive a cycle after the data; corrupt flips the low byte's bit only
        if (cap_r) par_r <= corrupt ? (ram_par_out ^ 2'h1) : ram_par_out;
        // Read bus toggles when not driven so stale data never passes
        ram_rd_data <= ~ram_rd_data;
        ram_par_in <= ~ram_par_in;
        if (cyc_start && cyc_on_card && cyc_write) begin
            mem_r <= wr_data;
            cap_r <= 1'b1;
        end
        if (cyc_start && cyc_on_card && !cyc_write) begin
            ram_rd_data <= mem_r;
            ram_par_in <= par_r;
        end
        if (cyc_start && !cyc_on_card) cnt_r <= ack_delay;
        else if (cpu_bus_err) cnt_r <= 0;
        else if (cnt_r > 0) cnt_r <= cnt_r - 1;
        // Acknowledge held until the core has taken it
        if (cnt_r == 1) system_bus_transfer_ack_n <= 1'b0;
        else if (cpu_dtack || cpu_bus_err) system_bus_transfer_ack_n <= 1'b1;
    end
endmodule : bep_far_model

/* File: bus_error_parity_logic_bench.sv */
`timescale 1ns/1ps
module bus_error_parity_logic_bench import bep_pkg::*;;
    logic core_clk, rst_b, cyc_start, cyc_write, cyc_user, cyc_on_card, seg_violation, boot_state, corrupt;
    logic [1:0]  cyc_byte_en, page_space_ctl, ram_par_in, ram_par_out;
    logic [23:0] cyc_addr;
    logic [15:0] wr_data, ram_rd_data;
    logic        system_bus_transfer_ack_n, ram_rd_inhibit, cpu_dtack, cpu_bus_err, parity_err;
    int          ack_delay, n_errors, check_count;
    bep_bus_error dut (.core_clk, .rst_b, .cyc_start, .cyc_write, .cyc_byte_en, .cyc_addr, .cyc_user,
        .cyc_on_card, .seg_violation, .page_space_ctl, .boot_state, .wr_data, .ram_par_in, .ram_rd_data,
        .system_bus_transfer_ack_n, .ram_par_out, .ram_rd_inhibit, .cpu_dtack, .cpu_bus_err, .parity_err);
    bep_far_model far (.core_clk, .cyc_start, .cyc_write, .cyc_on_card, .wr_data, .ram_par_out, .cpu_dtack,
        .cpu_bus_err, .ack_delay, .corrupt, .ram_rd_data, .ram_par_in, .system_bus_transfer_ack_n);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Error x skips the answer check; lat 0 skips the latency check
    task run(input logic w, u, oc, input logic [23:0] a, input logic [15:0] d, input logic err, input int lat);
        int n;
        @(negedge core_clk);
        {cyc_start, cyc_write, cyc_user, cyc_on_card, cyc_addr, wr_data} = {1'b1, w, u, oc, a, d};
        n = 1;
        @(negedge core_clk);
        cyc_start = 1'b0;
        while (cpu_dtack !== 1'b1 && cpu_bus_err !== 1'b1 && n < 800) begin
            n++;
            @(negedge core_clk);
        end
        if (err !== 1'bx) chk("bus_err", {15'h0, err}, {15'h0, cpu_bus_err});
        if (err !== 1'bx) chk("dtack", {15'h0, !err}, {15'h0, cpu_dtack});
        if (lat > 0) chk("latency", lat[15:0], n[15:0]);
        repeat (2) @(negedge core_clk);
    endtask : run
    task t_space();
        run(1'b0, 1'b1, 1'b0, 24'h200000, 16'h0, 1'b1, 1);
        run(1'b0, 1'b1, 1'b0, 24'h1FFFFF, 16'h0, 1'b0, 0);
        run(1'b0, 1'b0, 1'b0, 24'h200000, 16'h0, 1'b0, 0);
    endtask : t_space
    task t_maps();
        seg_violation = 1'b1;
        run(1'b1, 1'b0, 1'b1, 24'h000100, 16'h0, 1'b1, 1);
        seg_violation = 1'b0;
        for (int p = 0; p < 4; p++) begin
            page_space_ctl = p[1:0];
            run(1'b1, 1'b0, 1'b1, 24'h000100, 16'h0, p[1:0] == PAGE_INVALID, 1);
        end
        page_space_ctl = 2'h0;
    endtask : t_maps
    task t_off();
        ack_delay = 1000;
        run(1'b0, 1'b0, 1'b0, 24'h100000, 16'h0, 1'b1, TIMEOUT_CYC + 1);
        run(1'b1, 1'b0, 1'b1, 24'h000200, 16'h0, 1'b0, 1);
        ack_delay = 4;
    endtask : t_off
    task t_parity();
        run(1'b1, 1'b0, 1'b1, 24'h000100, 16'hA5C2, 1'b0, 1);
        chk("par_out", {14'h0, ~^8'hA5, ~^8'hC2}, {14'h0, ram_par_out});
        run(1'b0, 1'b0, 1'b1, 24'h000100, 16'h0, 1'b0, 1);
        chk("parity_err", 16'h0, {15'h0, parity_err});
        corrupt = 1'b1;
        run(1'b1, 1'b0, 1'b1, 24'h000100, 16'h3C01, 1'b0, 1);
        corrupt = 1'b0;
        cyc_byte_en = 2'h2;
        run(1'b0, 1'b0, 1'b1, 24'h000100, 16'h0, 1'b0, 1);
        chk("parity_err", 16'h0, {15'h0, parity_err});
        cyc_byte_en = 2'h3;
        run(1'b0, 1'b0, 1'b1, 24'h000100, 16'h0, 1'b0, 1);
        chk("parity_err", 16'h1, {15'h0, parity_err});
        run(1'b0, 1'b0, 1'b1, 24'h000100, 16'h0, 1'b1, 1);
        chk("parity_err", 16'h1, {15'h0, parity_err});
        run(1'b1, 1'b0, 1'b1, 24'h000100, 16'h1234, 1'b1, 1);
        chk("parity_err", 16'h0, {15'h0, parity_err});
    endtask : t_parity
    task t_boot();
        boot_state = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("rd_inhibit", 16'h1, {15'h0, ram_rd_inhibit});
        run(1'b0, 1'b0, 1'b0, 24'h100000, 16'h0, 1'b1, 0);
        corrupt = 1'b1;
        run(1'b1, 1'b0, 1'b1, 24'h000100, 16'h00FF, 1'b0, 1);
        corrupt = 1'b0;
        run(1'b0, 1'b0, 1'b1, 24'h000100, 16'h0, 1'b0, 1);
        chk("parity_err", 16'h0, {15'h0, parity_err});
        boot_state = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("rd_inhibit", 16'h0, {15'h0, ram_rd_inhibit});
    endtask : t_boot
    task test_done();
        $display("Checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        // Long enough for the timeout case plus a few dozen short cycles
        #60000;
        n_errors++;
        test_done();
    end
    initial begin
        {rst_b, cyc_start, cyc_write, cyc_user, cyc_on_card, seg_violation, boot_state, corrupt} = 8'h0;
        {cyc_byte_en, page_space_ctl, cyc_addr, wr_data, ack_delay} = {2'h3, 2'h0, 24'h0, 16'h0, 32'd4};
        {n_errors, check_count} = {32'd0, 32'd0};
        repeat (6) @(negedge core_clk);
        chk("rst_outs", 16'h1, {11'h0, ram_par_out, cpu_dtack, cpu_bus_err, ram_rd_inhibit});
        rst_b = 1'b1;
        t_space();
        t_maps();
        t_off();
        t_parity();
        t_boot();
        test_done();
    end
endmodule : bus_error_parity_logic_bench
